// ==== logic/eot_timer.sv ====
// 8-bit overflow timer with clock source select, sticky overflow flag and AXI4-Lite registers
`default_nettype none
module eot_timer
   import eot_pkg::*;
(
   input  wire logic                        CLOCK_I,
   input  wire logic                        RESET_I,
   input  wire logic                        EXT_COUNT_PIN_I,
   input  wire logic                        GLOBAL_IRQ_ENABLE_I,
   input  wire logic                        IRQ_VECTOR_ACK_I,
   input  wire logic [eot_pkg::ADDR_W-1:0]  S_AXI_AWADDR_I,
   input  wire logic                        S_AXI_AWVALID_I,
   output logic                             S_AXI_AWREADY_O,
   input  wire logic [eot_pkg::DATA_W-1:0]  S_AXI_WDATA_I,
   input  wire logic [3:0]                  S_AXI_WSTRB_I,
   input  wire logic                        S_AXI_WVALID_I,
   output logic                             S_AXI_WREADY_O,
   output logic [1:0]                       S_AXI_BRESP_O,
   output logic                             S_AXI_BVALID_O,
   input  wire logic                        S_AXI_BREADY_I,
   input  wire logic [eot_pkg::ADDR_W-1:0]  S_AXI_ARADDR_I,
   input  wire logic                        S_AXI_ARVALID_I,
   output logic                             S_AXI_ARREADY_O,
   output logic [eot_pkg::DATA_W-1:0]       S_AXI_RDATA_O,
   output logic [1:0]                       S_AXI_RRESP_O,
   output logic                             S_AXI_RVALID_O,
   input  wire logic                        S_AXI_RREADY_I,
   output logic                             IRQ_O
);
   import eot_pkg::*;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OFF_CTRL) || (a == OFF_COUNT) || (a == OFF_MASK) || (a == OFF_FLAG);
   endfunction : mapped

   // ---------------- tick generation
   logic [3:0] pre_tick;
   logic       pin_rise;
   logic       pin_fall;
   logic       timer_tick;
   logic [SEL_W-1:0] sel_ff;

   eot_prescaler #(
      .PRE_WIDTH (PRE_W)
   ) u_pre (
      .clk_i  (CLOCK_I),
      .rst_i  (RESET_I),
      .tick_o (pre_tick)
   );

   eot_pin_sync u_pin (
      .clk_i  (CLOCK_I),
      .rst_i  (RESET_I),
      .pin_i  (EXT_COUNT_PIN_I),
      .rise_o (pin_rise),
      .fall_o (pin_fall)
   );

   always_comb begin
      unique case (sel_ff)
         SEL_STOP:     timer_tick = 1'b0;
         SEL_DIV1:     timer_tick = 1'b1;
         SEL_DIV8:     timer_tick = pre_tick[0];
         SEL_DIV64:    timer_tick = pre_tick[1];
         SEL_DIV256:   timer_tick = pre_tick[2];
         SEL_DIV1024:  timer_tick = pre_tick[3];
         SEL_EXT_FALL: timer_tick = pin_fall;
         SEL_EXT_RISE: timer_tick = pin_rise;
      endcase
   end

   // ---------------- AXI4-Lite write channel
   logic                aw_got_ff;
   logic                w_got_ff;
   logic [ADDR_W-1:0]   awaddr_ff;
   logic [7:0]          wdata_ff;
   logic                wstrb0_ff;
   logic                bvalid_ff;
   logic [1:0]          bresp_ff;
   logic                nxt_aw_got;
   logic                nxt_w_got;
   logic [ADDR_W-1:0]   nxt_awaddr;
   logic [7:0]          nxt_wdata;
   logic                nxt_wstrb0;
   logic                nxt_bvalid;
   logic [1:0]          nxt_bresp;
   logic                wr_do;

   assign wr_do = aw_got_ff && w_got_ff && !bvalid_ff;

   always_comb begin
      nxt_aw_got = aw_got_ff;
      nxt_w_got  = w_got_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata  = wdata_ff;
      nxt_wstrb0 = wstrb0_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp  = bresp_ff;
      if (S_AXI_AWVALID_I && !aw_got_ff) begin
         nxt_aw_got = 1'b1;
         nxt_awaddr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && !w_got_ff) begin
         nxt_w_got  = 1'b1;
         nxt_wdata  = S_AXI_WDATA_I[7:0];
         nxt_wstrb0 = S_AXI_WSTRB_I[0];
      end
      if (wr_do) begin
         nxt_bvalid = 1'b1;
         nxt_bresp  = mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && S_AXI_BREADY_I) begin
         nxt_bvalid = 1'b0;
         nxt_aw_got = 1'b0;
         nxt_w_got  = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff  <= 8'h00;
         wstrb0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else begin
         aw_got_ff <= nxt_aw_got;
         w_got_ff  <= nxt_w_got;
         awaddr_ff <= nxt_awaddr;
         wdata_ff  <= nxt_wdata;
         wstrb0_ff <= nxt_wstrb0;
         bvalid_ff <= nxt_bvalid;
         bresp_ff  <= nxt_bresp;
      end
   end

   // ready is high while the channel's holding slot is empty
   logic awready_ff;
   logic wready_ff;
   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
      end else begin
         awready_ff <= !nxt_aw_got && !(S_AXI_AWVALID_I && !aw_got_ff);
         wready_ff  <= !nxt_w_got && !(S_AXI_WVALID_I && !w_got_ff);
      end
   end

   // a write only lands when byte lane 0 is enabled
   logic wr_ctrl;
   logic wr_count;
   logic wr_mask;
   logic wr_flag;
   assign wr_ctrl  = wr_do && wstrb0_ff && (awaddr_ff == OFF_CTRL);
   assign wr_count = wr_do && wstrb0_ff && (awaddr_ff == OFF_COUNT);
   assign wr_mask  = wr_do && wstrb0_ff && (awaddr_ff == OFF_MASK);
   assign wr_flag  = wr_do && wstrb0_ff && (awaddr_ff == OFF_FLAG);

   // ---------------- timer core
   logic [CNT_W-1:0] count_ff;
   logic             ovf_ff;
   logic             ovf_en_ff;
   logic             irq_ff;
   logic [SEL_W-1:0] nxt_sel;
   logic [CNT_W-1:0] nxt_count;
   logic             nxt_ovf;
   logic             nxt_ovf_en;
   logic             nxt_irq;
   logic             wrap;

   always_comb begin
      nxt_sel    = sel_ff;
      nxt_count  = count_ff;
      nxt_ovf    = ovf_ff;
      nxt_ovf_en = ovf_en_ff;
      wrap       = timer_tick && (count_ff == CNT_MAX);
      if (wr_ctrl) begin
         nxt_sel = wdata_ff[SEL_LSB +: SEL_W];
      end
      if (wr_mask) begin
         nxt_ovf_en = wdata_ff[OVF_BIT];
      end
      if (timer_tick) begin
         nxt_count = count_ff + 8'h01;
      end
      if (wr_count) begin
         nxt_count = wdata_ff;
      end
      // clears first so that a coincident overflow still sets the flag
      if (IRQ_VECTOR_ACK_I || (wr_flag && wdata_ff[OVF_BIT])) begin
         nxt_ovf = 1'b0;
      end
      if (wrap) begin
         nxt_ovf = 1'b1;
      end
      nxt_irq = nxt_ovf && nxt_ovf_en && GLOBAL_IRQ_ENABLE_I;
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         sel_ff    <= CTRL_RST[SEL_W-1:0];
         count_ff  <= COUNT_RST;
         ovf_ff    <= 1'b0;
         ovf_en_ff <= MASK_RST[OVF_BIT];
         irq_ff    <= 1'b0;
      end else begin
         sel_ff    <= nxt_sel;
         count_ff  <= nxt_count;
         ovf_ff    <= nxt_ovf;
         ovf_en_ff <= nxt_ovf_en;
         irq_ff    <= nxt_irq;
      end
   end

   // ---------------- AXI4-Lite read channel
   logic              rvalid_ff;
   logic              arready_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [1:0]        rresp_ff;
   logic              nxt_rvalid;
   logic              nxt_arready;
   logic [DATA_W-1:0] nxt_rdata;
   logic [1:0]        nxt_rresp;
   logic [7:0]        rd_byte;

   always_comb begin
      unique case (S_AXI_ARADDR_I)
         OFF_CTRL:  rd_byte = {5'h00, sel_ff};
         OFF_COUNT: rd_byte = count_ff;
         OFF_MASK:  rd_byte = {7'h00, ovf_en_ff};
         OFF_FLAG:  rd_byte = {7'h00, ovf_ff};
         default:   rd_byte = 8'h00;
      endcase
      nxt_rvalid  = rvalid_ff;
      nxt_arready = arready_ff;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      if (rvalid_ff && S_AXI_RREADY_I) begin
         nxt_rvalid  = 1'b0;
         nxt_arready = 1'b1;
      end else if (!rvalid_ff && arready_ff && S_AXI_ARVALID_I) begin
         nxt_rvalid  = 1'b1;
         nxt_arready = 1'b0;
         nxt_rdata   = {24'h000000, rd_byte};
         nxt_rresp   = mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      end else if (!rvalid_ff) begin
         nxt_arready = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= RESP_OKAY;
      end else begin
         rvalid_ff  <= nxt_rvalid;
         arready_ff <= nxt_arready;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end
   end

   assign S_AXI_AWREADY_O = awready_ff;
   assign S_AXI_WREADY_O  = wready_ff;
   assign S_AXI_BVALID_O  = bvalid_ff;
   assign S_AXI_BRESP_O   = bresp_ff;
   assign S_AXI_ARREADY_O = arready_ff;
   assign S_AXI_RVALID_O  = rvalid_ff;
   assign S_AXI_RDATA_O   = rdata_ff;
   assign S_AXI_RRESP_O   = rresp_ff;
   assign IRQ_O           = irq_ff;
endmodule : eot_timer
`default_nettype wire

// ==== logic/eot_pkg.sv ====
// package: register map, field layout, reset values and timing constants of the overflow timer
`default_nettype none
package eot_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 32;
   localparam int          CNT_W           = 8;
   localparam int          SEL_W           = 3;
   // register byte offsets
   localparam logic [3:0]  OFF_CTRL        = 4'h0;
   localparam logic [3:0]  OFF_COUNT       = 4'h4;
   localparam logic [3:0]  OFF_MASK        = 4'h8;
   localparam logic [3:0]  OFF_FLAG        = 4'hc;
   // field positions
   localparam int          SEL_LSB         = 0;
   localparam int          OVF_BIT         = 0;
   localparam int          GIE_BIT         = 7;
   // reset values and count limits
   localparam logic [7:0]  CTRL_RST        = 8'h00;
   localparam logic [7:0]  COUNT_RST       = 8'h00;
   localparam logic [7:0]  MASK_RST        = 8'h00;
   localparam logic [7:0]  CNT_MAX         = 8'hff;
   localparam logic [7:0]  CNT_BOTTOM      = 8'h00;
   // clock source selector codes
   localparam logic [2:0]  SEL_STOP        = 3'h0;
   localparam logic [2:0]  SEL_DIV1        = 3'h1;
   localparam logic [2:0]  SEL_DIV8        = 3'h2;
   localparam logic [2:0]  SEL_DIV64       = 3'h3;
   localparam logic [2:0]  SEL_DIV256      = 3'h4;
   localparam logic [2:0]  SEL_DIV1024     = 3'h5;
   localparam logic [2:0]  SEL_EXT_FALL    = 3'h6;
   localparam logic [2:0]  SEL_EXT_RISE    = 3'h7;
   // prescaler taps and bus response codes
   localparam int          PRE_W           = 10;
   localparam int          TAP8            = 2;
   localparam int          TAP64           = 5;
   localparam int          TAP256          = 7;
   localparam int          TAP1024         = 9;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : eot_pkg
`default_nettype wire

// ==== logic/eot_prescaler.sv ====
// free-running prescaler giving one-cycle ticks at io_clock/8, /64, /256 and /1024
`default_nettype none
module eot_prescaler
   import eot_pkg::*;
#(
   parameter int PRE_WIDTH = PRE_W
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   output logic [3:0]      tick_o
);
   logic [PRE_WIDTH-1:0] pre_ff;
   logic [PRE_WIDTH-1:0] nxt_pre;

   always_comb begin
      nxt_pre = pre_ff + 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= nxt_pre;
      end
   end

   // tick when the low bits up to the tap are all ones
   assign tick_o[0] = &pre_ff[TAP8:0];
   assign tick_o[1] = &pre_ff[TAP64:0];
   assign tick_o[2] = &pre_ff[TAP256:0];
   assign tick_o[3] = &pre_ff[TAP1024:0];
endmodule : eot_prescaler
`default_nettype wire

// ==== logic/eot_pin_sync.sv ====
// samples the external count pin and emits one-cycle rise and fall pulses
`default_nettype none
module eot_pin_sync (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       pin_i,
   output logic            rise_o,
   output logic            fall_o
);
   logic sync1_ff;
   logic sync2_ff;
   logic last_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         last_ff  <= 1'b0;
      end else begin
         sync1_ff <= pin_i;
         sync2_ff <= sync1_ff;
         last_ff  <= sync2_ff;
      end
   end

   assign rise_o = sync2_ff & ~last_ff;
   assign fall_o = ~sync2_ff & last_ff;
endmodule : eot_pin_sync
`default_nettype wire

// ==== verif/eot_timer_asserts.sv ====
// concurrent checks on the overflow timer's bus and interrupt ports
`default_nettype none
module eot_timer_asserts (
   input wire logic        CLOCK_I,
   input wire logic        RESET_I,
   input wire logic        GLOBAL_IRQ_ENABLE_I,
   input wire logic        IRQ_O,
   input wire logic        S_AXI_AWVALID_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic        S_AXI_WVALID_I,
   input wire logic        S_AXI_WREADY_O,
   input wire logic        S_AXI_BVALID_O,
   input wire logic        S_AXI_BREADY_I,
   input wire logic [1:0]  S_AXI_BRESP_O,
   input wire logic        S_AXI_ARVALID_I,
   input wire logic        S_AXI_ARREADY_O,
   input wire logic        S_AXI_RVALID_O,
   input wire logic        S_AXI_RREADY_I,
   input wire logic [31:0] S_AXI_RDATA_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RESET_I);
   irq_gate_a: assert property (!GLOBAL_IRQ_ENABLE_I |=> !IRQ_O)
      else $error("interrupt raised without global enable");
   b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
      |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write answer dropped");
   r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
      |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read answer dropped");
   rdata_top_a: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0)
      else $error("read data upper bits set");
   r_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read answer late");
   b_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O
      && S_AXI_WVALID_I && S_AXI_WREADY_O |=> ##1 S_AXI_BVALID_O) else $error("write answer late");
   w_refuse_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
      else $error("write taken while answering");
   ar_refuse_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read taken while answering");
   b_done_a: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
      |=> !S_AXI_BVALID_O && S_AXI_AWREADY_O) else $error("write path not reopened");
   cover property ($rose(IRQ_O));
   cover property (S_AXI_BVALID_O && !S_AXI_BREADY_I);
   cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
endmodule : eot_timer_asserts
bind eot_timer eot_timer_asserts eot_timer_asserts_inst (.*);
`default_nettype wire

// ==== verif/eot_timer_tb_top.sv ====
// self-checking bench for the overflow timer
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module eot_timer_tb_top import eot_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK_I = '0, RESET_I = '1, EXT_COUNT_PIN_I = '0, GLOBAL_IRQ_ENABLE_I = '0;
   logic IRQ_VECTOR_ACK_I = '0, S_AXI_AWVALID_I = '0, S_AXI_WVALID_I = '0, S_AXI_BREADY_I = '0;
   logic S_AXI_ARVALID_I = '0, S_AXI_RREADY_I = '0;
   logic [3:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0, S_AXI_WSTRB_I = 4'h1;
   logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
   logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
   logic IRQ_O;
   int miscompares = 0, comparisons = 0, cyc = 0, ar_cyc = 0;
   always #2 CLOCK_I = ~CLOCK_I;
   always @(posedge CLOCK_I) cyc <= cyc + 1;
   eot_timer eot_timer_inst (.*);
   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic guard(input int t);
      if (t > 5000) begin
         miscompares++;
         close_out();
      end
   endtask : guard
   // write with a one-cycle stall on the response channel
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      logic done;
      done = 1'h0;
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= {24'h0, d};
      S_AXI_AWVALID_I <= 1'h1;
      S_AXI_WVALID_I <= 1'h1;
      for (int t = 0; !done; t++) begin
         @(posedge CLOCK_I);
         guard(t);
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'h0;
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'h0;
         done = S_AXI_BVALID_O && S_AXI_BREADY_I;
         S_AXI_BREADY_I <= S_AXI_BVALID_O && !S_AXI_BREADY_I;
      end
      `CHK(S_AXI_BRESP_O, er)
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'h0;
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1'h1;
      for (int t = 0; !done; t++) begin
         @(posedge CLOCK_I);
         guard(t);
         if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARVALID_I <= 1'h0;
            ar_cyc = cyc;
         end
         done = S_AXI_RVALID_O && S_AXI_RREADY_I;
         S_AXI_RREADY_I <= S_AXI_RVALID_O && !S_AXI_RREADY_I;
      end
      d = S_AXI_RDATA_O;
      `CHK(S_AXI_RRESP_O, er)
   endtask : rd
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      logic [31:0] d;
      rd(a, d, RESP_OKAY);
      `CHK(d, {24'h0, e})
   endtask : rc
   task automatic t_reset;
      rc(OFF_CTRL, CTRL_RST);
      rc(OFF_COUNT, COUNT_RST);
      rc(OFF_MASK, MASK_RST);
      rc(OFF_FLAG, 8'h00);
      repeat (20) @(posedge CLOCK_I);
      rc(OFF_COUNT, COUNT_RST);
      $display("reset test done");
   endtask : t_reset
   task automatic t_regs;
      logic [31:0] d;
      wr(OFF_CTRL, 8'hf8, RESP_OKAY);
      rc(OFF_CTRL, 8'h00);
      wr(OFF_MASK, 8'hff, RESP_OKAY);
      rc(OFF_MASK, 8'h01);
      wr(4'h1, 8'hff, RESP_SLVERR);
      rd(4'h1, d, RESP_SLVERR);
      `CHK(d, 32'h0)
      S_AXI_WSTRB_I <= 4'h0;
      wr(OFF_COUNT, 8'h77, RESP_OKAY);
      S_AXI_WSTRB_I <= 4'h1;
      rc(OFF_COUNT, 8'h00);
      $display("register test done");
   endtask : t_regs
   task automatic t_rates;
      int n[6] = '{0, 1, 8, 64, 256, 1024};
      logic [31:0] c0;
      logic [31:0] c1;
      int d;
      int lo;
      for (int s = 0; s < 6; s++) begin
         wr(OFF_CTRL, 8'(s), RESP_OKAY);
         rd(OFF_COUNT, c0, RESP_OKAY);
         d = ar_cyc;
         repeat (4 * n[s] + 3) @(posedge CLOCK_I);
         rd(OFF_COUNT, c1, RESP_OKAY);
         d = ar_cyc - d;
         lo = (n[s] == 0) ? 0 : d / n[s];
         c1 = (c1 - c0) & 32'hff;
         `CHK(c1 == lo || (n[s] > 1 && c1 == lo + 1), 1'h1)
      end
      $display("rate test done");
   endtask : t_rates
   task automatic t_ovf;
      logic [31:0] d;
      wr(OFF_MASK, 8'h01, RESP_OKAY);
      GLOBAL_IRQ_ENABLE_I <= 1'h1;
      wr(OFF_COUNT, 8'hf0, RESP_OKAY);
      wr(OFF_CTRL, SEL_DIV1, RESP_OKAY);
      for (int t = 0; !IRQ_O; t++) begin
         @(posedge CLOCK_I);
         guard(t);
      end
      wr(OFF_COUNT, 8'h10, RESP_OKAY);
      rd(OFF_COUNT, d, RESP_OKAY);
      `CHK(d - 32'h10 < 32'h10, 1'h1)
      wr(OFF_CTRL, SEL_STOP, RESP_OKAY);
      rc(OFF_FLAG, 8'h01);
      GLOBAL_IRQ_ENABLE_I <= 1'h0;
      repeat (3) @(posedge CLOCK_I);
      `CHK(IRQ_O, 1'h0)
      GLOBAL_IRQ_ENABLE_I <= 1'h1;
      wr(OFF_FLAG, 8'h00, RESP_OKAY);
      rc(OFF_FLAG, 8'h01);
      `CHK(IRQ_O, 1'h1)
      IRQ_VECTOR_ACK_I <= 1'h1;
      @(posedge CLOCK_I);
      IRQ_VECTOR_ACK_I <= 1'h0;
      rc(OFF_FLAG, 8'h00);
      `CHK(IRQ_O, 1'h0)
      wr(OFF_MASK, 8'h00, RESP_OKAY);
      wr(OFF_COUNT, 8'hfe, RESP_OKAY);
      wr(OFF_CTRL, SEL_DIV1, RESP_OKAY);
      wr(OFF_CTRL, SEL_STOP, RESP_OKAY);
      rc(OFF_FLAG, 8'h01);
      `CHK(IRQ_O, 1'h0)
      wr(OFF_FLAG, 8'h01, RESP_OKAY);
      rc(OFF_FLAG, 8'h00);
      $display("overflow test done");
   endtask : t_ovf
   task automatic t_ext;
      wr(OFF_COUNT, 8'h00, RESP_OKAY);
      for (int m = 0; m < 2; m++) begin
         wr(OFF_CTRL, m ? SEL_EXT_FALL : SEL_EXT_RISE, RESP_OKAY);
         // half periods of three cycles keep the source within sampling range
         repeat (3) begin
            EXT_COUNT_PIN_I <= 1'h1;
            repeat (3) @(posedge CLOCK_I);
            EXT_COUNT_PIN_I <= 1'h0;
            repeat (3) @(posedge CLOCK_I);
         end
         repeat (4) @(posedge CLOCK_I);
         rc(OFF_COUNT, 8'(3 * m + 3));
      end
      wr(OFF_CTRL, SEL_STOP, RESP_OKAY);
      $display("external pin test done");
   endtask : t_ext
   initial begin
      repeat (12) @(posedge CLOCK_I);
      RESET_I <= 1'h0;
      repeat (2) @(posedge CLOCK_I);
      t_reset();
      t_regs();
      t_rates();
      t_ovf();
      t_ext();
      close_out();
   end
endmodule : eot_timer_tb_top
`default_nettype wire
